// ---- pkg/pcs_pkg.sv ----
`default_nettype none
package pcs_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS       = 4;
  localparam int unsigned SYNC_IN_DELAY_NS    = 760;
  localparam int unsigned SYNC_OUT_LEAD_NS    = 760;
  localparam int unsigned SYNC_OUT_WIDTH_NS   = 640;
  localparam int unsigned JITTER_LIMIT_NS     = 280;
  localparam int unsigned PHASE_NARROW_NS     = 160;
  localparam int unsigned PHASE_WIDE_NS       = 640;
  localparam int unsigned EXTRA_STEP_NS       = 20;

  localparam logic [15:0] SYNC_IN_DELAY_CYC   = 16'(SYNC_IN_DELAY_NS / CLK_PERIOD_NS);
  localparam logic [15:0] SYNC_OUT_LEAD_CYC   = 16'(SYNC_OUT_LEAD_NS / CLK_PERIOD_NS);
  localparam logic [15:0] SYNC_OUT_WIDTH_CYC  =
    16'((SYNC_OUT_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Load-to-pin register stages of the sync output
  localparam logic [15:0] SYNC_OUT_PIPE_CYC   = 16'd2;
  localparam logic [15:0] JITTER_LIMIT_CYC    = 16'(JITTER_LIMIT_NS / CLK_PERIOD_NS);
  localparam logic [15:0] PHASE_NARROW_CYC    = 16'(PHASE_NARROW_NS / CLK_PERIOD_NS);
  localparam logic [15:0] PHASE_WIDE_CYC      = 16'(PHASE_WIDE_NS / CLK_PERIOD_NS);
  localparam logic [15:0] EXTRA_STEP_CYC      = 16'(EXTRA_STEP_NS / CLK_PERIOD_NS);

  // Period windows in percent, and good-period count for frequency capture
  localparam logic [23:0] CAP_LO_PCT          = 24'd90;
  localparam logic [23:0] CAP_HI_PCT          = 24'd110;
  localparam logic [23:0] HOLD_LO_PCT         = 24'd89;
  localparam logic [23:0] HOLD_HI_PCT         = 24'd114;
  localparam logic [23:0] PCT_SCALE           = 24'd100;
  localparam logic [6:0]  GOOD_CYCLES         = 7'd64;

  // Register addresses
  localparam logic [15:0] SYNC_EXTRA_DELAY_ADDR = 16'hFE11;
  localparam logic [15:0] SYNC_CONTROL_ADDR     = 16'hFE12;
  localparam logic [15:0] EDGE_REF_SEL0_ADDR    = 16'hFE6D;
  localparam logic [15:0] EDGE_REF_SEL1_ADDR    = 16'hFE6E;
  localparam logic [15:0] EDGE_REF_SEL2_ADDR    = 16'hFE6F;
  localparam logic [15:0] SYNC_STATUS_ADDR      = 16'hFE70;

  // Reset values
  localparam logic [7:0]  REG_RESET           = 8'h00;

  // Sync control fields
  localparam int unsigned CTRL_EN0_BIT        = 0;
  localparam int unsigned CTRL_EN1_BIT        = 3;
  localparam int unsigned CTRL_OUT_C_BIT      = 4;
  localparam int unsigned CTRL_OUT_D_BIT      = 5;
  localparam int unsigned CTRL_PHASE_BIT      = 6;

  typedef enum logic [2:0] {
    PCS_FREE,
    PCS_FREQ_CAP,
    PCS_PHASE_CAP,
    PCS_LOCKED,
    PCS_HOLD
  } pcs_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  data;
  } pcs_reg_req_t;

endpackage
`default_nettype wire

// ---- hw/pcs_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcs_sync (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // Register port
  input  wire pcs_pkg::pcs_reg_req_t reg_req,
  output var  logic [7:0]         reg_rd_data,
  // Configuration
  input  wire logic [15:0]        switching_period,
  // Pins and faults
  input  wire logic               sync_in,
  input  wire logic               supply_overvoltage_fault,
  input  wire logic               pwm_c_in,
  input  wire logic               pwm_d_in,
  output var  logic               pwm_out_c,
  output var  logic               pwm_out_d,
  // PWM engine timebase
  output var  logic               cycle_start,
  output var  logic [15:0]        period_now,
  output var  logic [15:0]        half_period,
  output var  logic [23:0]        edge_half_ref,
  output var  logic               sync_locked
);
  import pcs_pkg::*;

  // Register file
  logic [7:0] extra_q, extra_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] esel0_q, esel0_d;
  logic [7:0] esel1_q, esel1_d;
  logic [7:0] esel2_q, esel2_d;
  logic [7:0] rd_q, rd_d;

  // Pin synchronisers
  logic [1:0] sin_sync_q;
  logic [1:0] ov_sync_q;
  logic       sin_prev_q;
  logic       sin_rise;

  // Measurement and state
  pcs_state_t  state_q, state_d;
  logic [15:0] meas_q, meas_d;
  logic [15:0] last_per_q, last_per_d;
  logic        have_edge_q, have_edge_d;
  logic [6:0]  good_q, good_d;
  logic [15:0] ref_per_q, ref_per_d;
  logic [15:0] dly_q, dly_d;
  logic        dly_run_q, dly_run_d;
  logic        ext_start;

  // Timebases
  logic [15:0] pwm_cnt_q, pwm_cnt_d;
  logic [15:0] osc_cnt_q, osc_cnt_d;
  logic        start_q, start_d;

  // Sync output
  logic [15:0] so_cnt_q, so_cnt_d;
  logic        out_c_q, out_c_d;
  logic        out_d_q, out_d_d;

  // Helper terms
  logic        enabled;
  logic [15:0] cur_per;
  logic [23:0] per100;
  logic [23:0] int_lo90, int_hi110, int_lo89, int_hi114;
  logic        in_cap, in_hold, jitter_bad, lost;
  logic [15:0] jit_diff;
  logic [15:0] phase_rng;
  logic [15:0] pwm_dist, osc_dist;
  logic        pwm_wrap, osc_wrap;

  // Register access
  always_comb begin
    extra_d = extra_q;
    ctrl_d  = ctrl_q;
    esel0_d = esel0_q;
    esel1_d = esel1_q;
    esel2_d = esel2_q;
    rd_d    = rd_q;
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        SYNC_EXTRA_DELAY_ADDR: extra_d = reg_req.data;
        SYNC_CONTROL_ADDR:     ctrl_d  = reg_req.data;
        EDGE_REF_SEL0_ADDR:    esel0_d = reg_req.data;
        EDGE_REF_SEL1_ADDR:    esel1_d = reg_req.data;
        EDGE_REF_SEL2_ADDR:    esel2_d = reg_req.data;
        default:               ;
      endcase
    end
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        SYNC_EXTRA_DELAY_ADDR: rd_d = extra_q;
        SYNC_CONTROL_ADDR:     rd_d = ctrl_q;
        EDGE_REF_SEL0_ADDR:    rd_d = esel0_q;
        EDGE_REF_SEL1_ADDR:    rd_d = esel1_q;
        EDGE_REF_SEL2_ADDR:    rd_d = esel2_q;
        SYNC_STATUS_ADDR:      rd_d = {5'h00, state_q};
        default:               rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      extra_q <= REG_RESET;
      ctrl_q  <= REG_RESET;
      esel0_q <= REG_RESET;
      esel1_q <= REG_RESET;
      esel2_q <= REG_RESET;
      rd_q    <= REG_RESET;
    end else begin
      extra_q <= extra_d;
      ctrl_q  <= ctrl_d;
      esel0_q <= esel0_d;
      esel1_q <= esel1_d;
      esel2_q <= esel2_d;
      rd_q    <= rd_d;
    end
  end

  // Synchronise pins, find sync input rising edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sin_sync_q <= 2'h0;
      ov_sync_q  <= 2'h0;
      sin_prev_q <= 1'b0;
    end else begin
      sin_sync_q <= {sin_sync_q[0], sync_in};
      ov_sync_q  <= {ov_sync_q[0], supply_overvoltage_fault};
      sin_prev_q <= sin_sync_q[1];
    end
  end

  assign sin_rise = sin_sync_q[1] & ~sin_prev_q;

  // Period windows and phase tests
  always_comb begin
    enabled    = ctrl_q[CTRL_EN0_BIT] & ctrl_q[CTRL_EN1_BIT];
    cur_per    = (state_q == PCS_LOCKED || state_q == PCS_HOLD) ?
                 ref_per_q : switching_period;
    per100     = {8'h00, meas_q} * PCT_SCALE;
    int_lo90   = {8'h00, switching_period} * CAP_LO_PCT;
    int_hi110  = {8'h00, switching_period} * CAP_HI_PCT;
    int_lo89   = {8'h00, switching_period} * HOLD_LO_PCT;
    int_hi114  = {8'h00, switching_period} * HOLD_HI_PCT;
    in_cap     = (per100 >= int_lo90) && (per100 <= int_hi110);
    in_hold    = (per100 >= int_lo89) && (per100 <= int_hi114);
    jit_diff   = (meas_q > last_per_q) ? meas_q - last_per_q : last_per_q - meas_q;
    jitter_bad = have_edge_q && (jit_diff > JITTER_LIMIT_CYC);
    lost       = per100 > int_hi114;
    phase_rng  = ctrl_q[CTRL_PHASE_BIT] ? PHASE_WIDE_CYC : PHASE_NARROW_CYC;
    pwm_dist   = (pwm_cnt_q < (cur_per - pwm_cnt_q)) ? pwm_cnt_q : cur_per - pwm_cnt_q;
    osc_dist   = (pwm_cnt_q < (ref_per_q - pwm_cnt_q)) ? pwm_cnt_q : ref_per_q - pwm_cnt_q;
    pwm_wrap   = pwm_cnt_q >= cur_per - 16'd1;
    osc_wrap   = osc_cnt_q >= switching_period - 16'd1;
  end

  // Delayed external start after each rising edge while both enables are set
  always_comb begin
    dly_d     = dly_q;
    dly_run_d = dly_run_q;
    ext_start = 1'b0;
    if (sin_rise && enabled) begin
      dly_d     = 16'(SYNC_IN_DELAY_CYC + 16'(extra_q) * EXTRA_STEP_CYC);
      dly_run_d = 1'b1;
    end else if (dly_run_q) begin
      if (dly_q <= 16'd1) begin
        dly_run_d = 1'b0;
        ext_start = 1'b1;
      end else begin
        dly_d = dly_q - 16'd1;
      end
    end
  end

  // Frequency capture, phase capture, lock and hold
  always_comb begin
    state_d     = state_q;
    meas_d      = (meas_q == 16'hFFFF) ? meas_q : meas_q + 16'd1;
    last_per_d  = last_per_q;
    have_edge_d = have_edge_q;
    good_d      = good_q;
    ref_per_d   = ref_per_q;
    if (!enabled) begin
      state_d     = PCS_FREE;
      have_edge_d = 1'b0;
      good_d      = 7'd0;
      meas_d      = 16'd0;
    end else begin
      if (sin_rise) begin
        meas_d      = 16'd1;
        last_per_d  = meas_q;
        have_edge_d = 1'b1;
      end
      unique case (state_q)
        PCS_FREE: begin
          state_d = PCS_FREQ_CAP;
          good_d  = 7'd0;
        end
        PCS_FREQ_CAP: begin
          if (sin_rise && have_edge_q) begin
            if (!in_cap) begin
              good_d = 7'd0;
            end else if (good_q >= GOOD_CYCLES - 7'd1) begin
              ref_per_d = meas_q;
              state_d   = PCS_PHASE_CAP;
            end else begin
              good_d = good_q + 7'd1;
            end
          end
        end
        PCS_PHASE_CAP: begin
          if (sin_rise && !in_cap) begin
            state_d = PCS_FREQ_CAP;
            good_d  = 7'd0;
          end else if (ext_start && pwm_dist <= phase_rng) begin
            state_d = PCS_LOCKED;
          end
        end
        PCS_LOCKED: begin
          if (lost || (sin_rise && (!in_hold || jitter_bad))) begin
            state_d = PCS_HOLD;
          end else if (sin_rise) begin
            ref_per_d = meas_q;
          end
        end
        PCS_HOLD: begin
          if (osc_wrap && osc_dist <= phase_rng) begin
            state_d = PCS_FREQ_CAP;
            good_d  = 7'd0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= PCS_FREE;
      meas_q      <= 16'h0000;
      last_per_q  <= 16'h0000;
      have_edge_q <= 1'b0;
      good_q      <= 7'h00;
      ref_per_q   <= 16'h0000;
      dly_q       <= 16'h0000;
      dly_run_q   <= 1'b0;
    end else begin
      state_q     <= state_d;
      meas_q      <= meas_d;
      last_per_q  <= last_per_d;
      have_edge_q <= have_edge_d;
      good_q      <= good_d;
      ref_per_q   <= ref_per_d;
      dly_q       <= dly_d;
      dly_run_q   <= dly_run_d;
    end
  end

  // PWM timebase and internal oscillator
  always_comb begin
    start_d   = 1'b0;
    osc_cnt_d = osc_wrap ? 16'd0 : osc_cnt_q + 16'd1;
    if (state_q == PCS_LOCKED && ext_start) begin
      pwm_cnt_d = 16'd0;
      start_d   = 1'b1;
    end else if (pwm_wrap) begin
      pwm_cnt_d = 16'd0;
      start_d   = 1'b1;
    end else begin
      pwm_cnt_d = pwm_cnt_q + 16'd1;
    end
    if (state_q == PCS_HOLD && osc_wrap && osc_dist <= phase_rng) begin
      pwm_cnt_d = 16'd0;
      start_d   = 1'b1;
    end
  end

  // Sync output pulse on pin C or D
  always_comb begin
    so_cnt_d = (so_cnt_q != 16'd0) ? so_cnt_q - 16'd1 : 16'd0;
    if (pwm_cnt_q == cur_per - SYNC_OUT_LEAD_CYC - SYNC_OUT_PIPE_CYC) begin
      so_cnt_d = SYNC_OUT_WIDTH_CYC;
    end
    if (ov_sync_q[1]) begin
      so_cnt_d = 16'd0;
    end
    out_c_d = ctrl_q[CTRL_OUT_C_BIT] ? (so_cnt_q != 16'd0) : pwm_c_in;
    out_d_d = ctrl_q[CTRL_OUT_D_BIT] ? (so_cnt_q != 16'd0) : pwm_d_in;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt_q <= 16'h0000;
      osc_cnt_q <= 16'h0000;
      start_q   <= 1'b0;
      so_cnt_q  <= 16'h0000;
      out_c_q   <= 1'b0;
      out_d_q   <= 1'b0;
    end else begin
      pwm_cnt_q <= pwm_cnt_d;
      osc_cnt_q <= osc_cnt_d;
      start_q   <= start_d;
      so_cnt_q  <= so_cnt_d;
      out_c_q   <= out_c_d;
      out_d_q   <= out_d_d;
    end
  end

  // Registered outputs for the PWM engine
  logic [15:0] period_q;
  logic [15:0] half_q;
  logic [23:0] eref_q;
  logic        locked_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_q <= 16'h0000;
      half_q   <= 16'h0000;
      eref_q   <= 24'h000000;
      locked_q <= 1'b0;
    end else begin
      period_q <= cur_per;
      half_q   <= {1'b0, cur_per[15:1]};
      eref_q   <= {esel2_q, esel1_q, esel0_q};
      locked_q <= state_q == PCS_LOCKED;
    end
  end

  assign reg_rd_data   = rd_q;
  assign pwm_out_c     = out_c_q;
  assign pwm_out_d     = out_d_q;
  assign cycle_start   = start_q;
  assign period_now    = period_q;
  assign half_period   = half_q;
  assign edge_half_ref = eref_q;
  assign sync_locked   = locked_q;

endmodule // pcs_sync
`default_nettype wire

// ---- sim/pcs_sync_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcs_sync_partner (
  // Control
  input  wire logic        en,
  input  wire logic [31:0] period_ns,
  // Sync line
  output var  logic        sync_out
);
  // Idle low between pulses; 400 ns high clears the minimum width
  always begin
    if (en) begin
      sync_out = 1'b1;
      #400;
      sync_out = 1'b0;
      #(period_ns - 400);
    end else begin
      sync_out = 1'b0;
      #63.3;
    end
  end
endmodule  // pcs_sync_partner
`default_nettype wire

// ---- sim/pcs_sync_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcs_sync_properties (
  // Clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  // Register port
  input wire pcs_pkg::pcs_reg_req_t reg_req,
  input wire logic [7:0]            reg_rd_data,
  input wire logic [15:0]           switching_period,
  // Pins
  input wire logic                  sync_in,
  input wire logic                  supply_overvoltage_fault,
  input wire logic                  pwm_c_in,
  input wire logic                  pwm_d_in,
  input wire logic                  pwm_out_c,
  input wire logic                  pwm_out_d,
  // Timebase
  input wire logic                  cycle_start,
  input wire logic [15:0]           period_now,
  input wire logic [15:0]           half_period,
  input wire logic [23:0]           edge_half_ref,
  input wire logic                  sync_locked
);
  import pcs_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] ctl_q, ctl_d, xd_q, xd_d, hi_q, hi_d, st_q, st_d;
  // Shadow of control, extra delay and high-run length of pin C
  always_comb begin
    ctl_d = ctl_q;
    xd_d  = xd_q;
    if (reg_req.wr && reg_req.addr == SYNC_CONTROL_ADDR) ctl_d = reg_req.data;
    if (reg_req.wr && reg_req.addr == SYNC_EXTRA_DELAY_ADDR) xd_d = reg_req.data;
    hi_d = pwm_out_c ? hi_q + 8'h01 : 8'h00;
    // Cycles since pin C select last changed, saturating
    st_d = (ctl_d[4] != ctl_q[4]) ? 8'h00 : st_q + {7'h00, st_q != 8'hFF};
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= 8'h00;
      xd_q  <= 8'h00;
      hi_q  <= 8'h00;
      st_q  <= 8'h00;
    end else begin
      ctl_q <= ctl_d;
      xd_q  <= xd_d;
      hi_q  <= hi_d;
      st_q  <= st_d;
    end
  end
  sequence s_edge;
    ($rose(sync_in) && xd_q == 8'h00) ##6 sync_locked;
  endsequence
  sequence s_c_rise;
    $rose(pwm_out_c) && ctl_q[4] && st_q == 8'hFF && !sync_locked;
  endsequence
  property p_cs_pulse; cycle_start |=> !cycle_start; endproperty
  property p_lock_en; $rose(sync_locked) |-> ctl_q[0] && ctl_q[3]; endproperty
  property p_lock_per;
    $rose(sync_locked) |-> ##[0:3] (32'(period_now) * 100 >= 32'(switching_period) * 90 &&
      32'(period_now) * 100 <= 32'(switching_period) * 110);
  endproperty
  property p_resync; s_edge |-> ##[184:194] cycle_start; endproperty
  property p_width;
    $fell(pwm_out_c) && ctl_q[4] && st_q == 8'hFF && !supply_overvoltage_fault |->
      hi_q == 8'd160;
  endproperty
  property p_lead; s_c_rise |-> ##190 cycle_start; endproperty
  property p_ov; (ctl_q[4] && supply_overvoltage_fault)[*5] |-> !pwm_out_c; endproperty
  property p_pass; !ctl_q[4] && !reg_req.wr |=> pwm_out_c == $past(pwm_c_in); endproperty
  property p_rd_ctl;
    reg_req.rd && reg_req.addr == SYNC_CONTROL_ADDR |=> reg_rd_data == $past(ctl_q);
  endproperty
  a_cs_pulse: assert property (p_cs_pulse)
    else $error("cycle start longer than one cycle");
  a_lock_en: assert property (p_lock_en)
    else $error("lock without both enables");
  a_lock_per: assert property (p_lock_per)
    else $error("locked period out of range");
  a_resync: assert property (p_resync)
    else $error("no cycle start after sync edge");
  a_width: assert property (p_width)
    else $error("sync pulse width wrong");
  a_lead: assert property (p_lead)
    else $error("sync pulse lead wrong");
  a_ov: assert property (p_ov)
    else $error("sync output during overvoltage");
  a_pass: assert property (p_pass)
    else $error("pin C pass-through wrong");
  a_rd_ctl: assert property (p_rd_ctl)
    else $error("control readback wrong");
endmodule  // pcs_sync_properties
bind pcs_sync pcs_sync_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_req(reg_req), .reg_rd_data(reg_rd_data), .switching_period(switching_period),
  .sync_in(sync_in), .supply_overvoltage_fault(supply_overvoltage_fault),
  .pwm_c_in(pwm_c_in), .pwm_d_in(pwm_d_in), .pwm_out_c(pwm_out_c), .pwm_out_d(pwm_out_d),
  .cycle_start(cycle_start), .period_now(period_now), .half_period(half_period),
  .edge_half_ref(edge_half_ref), .sync_locked(sync_locked));
`default_nettype wire

// ---- sim/pcs_sync_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcs_sync_tb;
  import pcs_pkg::*;
  localparam logic [15:0] PER = 16'd560;
  logic         ref_clk = 1'b0, rst_n = 1'b0, ov = 1'b0, pc = 1'b0, pd = 1'b0;
  logic         en = 1'b0, rnd = 1'b0;
  pcs_reg_req_t req = '0;
  logic [7:0]   rdat, e;
  logic         oc, od, cs, lk, sync_in;
  logic [15:0]  pn, hp;
  logic [23:0]  ehr;
  logic [31:0]  ext_ns;
  logic [7:0]   v [5];
  logic [15:0]  ad [6] = '{SYNC_EXTRA_DELAY_ADDR, SYNC_CONTROL_ADDR, EDGE_REF_SEL0_ADDR,
                         EDGE_REF_SEL1_ADDR, EDGE_REF_SEL2_ADDR, SYNC_STATUS_ADDR};
  int           fail_count = 0, compares = 0, seed = 47, n, d0, d1, hits;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    pc <= rnd ? 1'($random(seed)) : 1'b0;
    pd <= rnd ? 1'($random(seed)) : 1'b0;
  end
  pcs_sync dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(req), .reg_rd_data(rdat),
    .switching_period(PER), .sync_in(sync_in), .supply_overvoltage_fault(ov),
    .pwm_c_in(pc), .pwm_d_in(pd), .pwm_out_c(oc), .pwm_out_d(od), .cycle_start(cs),
    .period_now(pn), .half_period(hp), .edge_half_ref(ehr), .sync_locked(lk));
  pcs_sync_partner peer (.en(en), .period_ns(ext_ns), .sync_out(sync_in));
  task automatic print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk) req <= '{w, !w, a, d};
    @(posedge ref_clk) req <= '0;
    #1;
  endtask
  function automatic logic cond(input int k);
    case (k)
      0: return lk;
      1: return !lk;
      2: return sync_in;
      3: return !sync_in;
      4: return cs;
      5: return oc;
      6: return !oc;
      7: return od;
      8: return !od;
      default: return pn === PER;
    endcase
  endfunction
  // Bounded wait on a condition, counting cycles
  task automatic wait_on(input int k, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end while (cond(k) !== 1'b1 && cnt < lim);
    if (cond(k) !== 1'b1) begin
      fail_count++;
      $display("FAIL %0t timeout on condition %0d", $time, k);
      print_verdict();
    end
  endtask
  task automatic edge_delay(output int dl);
    wait_on(3, 1000, dl);
    wait_on(2, 1000, dl);
    wait_on(4, 1000, dl);
  endtask
  initial begin
    ext_ns = 2320 + 4 * ($unsigned($random(seed)) % 11);
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rnd <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rw(0, ad[i], 8'h00);
      chk(rdat, REG_RESET);
    end
    for (int i = 2; i < 5; i++) begin
      v[i] = 8'($random(seed));
      rw(1, ad[i], v[i]);
    end
    for (int i = 2; i < 5; i++) begin
      rw(0, ad[i], 8'h00);
      chk(rdat, v[i]);
    end
    chk(ehr, {v[4], v[3], v[2]});
    rw(1, 16'hFE13, 8'h5A);
    rw(0, 16'hFE13, 8'h00);
    chk(rdat, 8'h00);
    $display("test registers done");
    rw(1, SYNC_CONTROL_ADDR, 8'h08);
    en <= 1'b1;
    repeat (10 * 580) @(posedge ref_clk);
    #1;
    chk(lk, 1'b0);
    chk(pn, PER);
    $display("test one enable done");
    rw(1, SYNC_CONTROL_ADDR, 8'h49);
    wait_on(0, 52000, n);
    chk(n >= 63 * 580, 1'b1);
    repeat (5) @(posedge ref_clk);
    #1;
    chk(pn, ext_ns / 4);
    chk(hp, ext_ns / 8);
    edge_delay(d0);
    chk(d0 >= 190 && d0 <= 200, 1'b1);
    e = 8'd1 + 8'($unsigned($random(seed)) % 40);
    rw(1, SYNC_EXTRA_DELAY_ADDR, e);
    edge_delay(d1);
    edge_delay(d1);
    chk(d1 - d0, 5 * e);
    $display("test lock done");
    ext_ns = ext_ns - 300;
    wait_on(1, 4 * 600, n);
    en <= 1'b0;
    wait_on(9, 20 * 600, n);
    $display("test unlock done");
    rnd <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rw(1, SYNC_CONTROL_ADDR, 8'h10);
    wait_on(6, 400, n);
    wait_on(5, 1200, n);
    wait_on(6, 400, n);
    chk(n, 32'd160);
    wait_on(4, 400, n);
    chk(n, SYNC_OUT_LEAD_CYC - SYNC_OUT_WIDTH_CYC);
    rw(1, SYNC_CONTROL_ADDR, 8'h30);
    wait_on(8, 400, n);
    wait_on(7, 1200, n);
    wait_on(8, 400, n);
    chk(n, 32'd160);
    @(posedge ref_clk) ov <= 1'b1;
    repeat (4) @(posedge ref_clk);
    hits = 0;
    repeat (1200) begin
      @(posedge ref_clk);
      #1;
      hits += (od !== 1'b0);
    end
    chk(hits, 0);
    @(posedge ref_clk) ov <= 1'b0;
    wait_on(7, 1200, n);
    $display("test master done");
    print_verdict();
  end
endmodule  // pcs_sync_tb
`default_nettype wire
